// >>> verilog/bes_pkg.sv
// Package of constants and types for the bus error status logger.
package bes_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 64;

	// Register map, byte addresses.
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_CONFIG = 8'h08;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h18;
	localparam logic [7:0] OFS_IRQ_CLEAR = 8'h20;
	localparam logic [7:0] OFS_TIMEOUT_COUNT = 8'h28;

	// Bit positions inside machine_check_bank_status.
	localparam int BIT_EXT_BUS_INIT_SIGNAL = 35;
	localparam int BIT_RSP_PARITY = 36;
	localparam int BIT_SPLIT_HARD = 37;
	localparam int BIT_TIMEOUT = 38;
	localparam int BIT_HARD_ERR = 42;
	localparam int BIT_INTERNAL = 43;
	localparam int BIT_ADDR_PARITY = 44;
	localparam int BIT_UNCORRECTABLE_ECC_FLAG = 45;
	localparam int BIT_CORRECTED_ECC_FLAG = 46;
	localparam int SYN_LSB = 47;
	localparam int SYN_MSB = 54;

	// Interrupt status and enable layout, one bit per logged event.
	localparam int IRQ_EXT_BUS_INIT_SIGNAL = 0;
	localparam int IRQ_RSP_PARITY = 1;
	localparam int IRQ_SPLIT_HARD = 2;
	localparam int IRQ_TIMEOUT = 3;
	localparam int IRQ_HARD_ERR = 4;
	localparam int IRQ_INTERNAL = 5;
	localparam int IRQ_ADDR_PARITY = 6;
	localparam int IRQ_UNCORRECTABLE_ECC_FLAG = 7;
	localparam int IRQ_CORRECTED_ECC_FLAG = 8;
	localparam int IRQ_W = 9;

	// Configuration fields.
	localparam int CFG_RATIO_LSB = 0;
	localparam int CFG_RATIO_MSB = 1;
	localparam int CFG_LONG_COUNTER = 2;
	localparam int CFG_XTAL_SRC = 3;
	localparam logic [1:0] RATIO_HALF = 2'h0;
	localparam logic [1:0] RATIO_THIRD = 2'h1;
	localparam logic [1:0] RATIO_QUARTER = 2'h2;
	localparam logic [3:0] CFG_RESET = 4'h0;

	// Timeout chain.
	localparam int PRESCALE_W = 8;
	localparam logic [7:0] PRESCALE_LAST = 8'h7f;
	localparam int TO_SHORT_W = 15;
	localparam int TO_LONG_W = 23;
	localparam int ADDRESS_PARITY_FAILURE_LIMIT = 2;

	typedef struct packed {
		logic bus_init;
		logic [2:0] rs;
		logic rsp;
		logic rs_valid;
		logic xtal;
	} bes_pins_t;

	typedef struct packed {
		bes_pins_t pin_s1;
		bes_pins_t pin_s2;
		logic xtal_prev;
		logic bus_init_prev;
		logic [3:0] cfg;
		logic [1:0] div_cnt;
		logic [7:0] prescale;
		logic [23:0] to_cnt;
		logic to_bus_init_signal;
		logic [1:0] address_parity_failure_cnt;
		logic [63:0] status;
		logic [8:0] irq_status;
		logic [8:0] irq_enable;
		logic irq;
		logic [63:0] rdata;
	} bes_state_t;

	localparam bes_state_t STATE_RESET = '{
		pin_s1: '0, pin_s2: '0, xtal_prev: 1'b0, bus_init_prev: 1'b0,
		cfg: CFG_RESET, div_cnt: 2'h0, prescale: 8'h00, to_cnt: 24'h000000,
		to_bus_init_signal: 1'b0, address_parity_failure_cnt: 2'h0, status: 64'h0000000000000000,
		irq_status: 9'h000, irq_enable: 9'h000, irq: 1'b0,
		rdata: 64'h0000000000000000};

endpackage

// >>> verilog/bes_logger.sv
// Bus error status logger: sticky model-specific error bits and retirement timeout.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////

// Functional notes
// - External bus-init received sets bit 35.
// - Response status parity error sets bit 36.
// - Hard error on split access sets bit 37.
// - Retirement timeout sets bit 38.
// - Timeout is carry out of 15-bit counter.
// - Retire, exception, reset, timeout bus-init clear counter.
// - Divide-by-128 prescaler steps the timeout counter.
// - Bus clock is half, third or quarter.
// - Timeout bit is never overwritten while set.
// - Initiated transaction hard error sets bit 42.
// - Internal failure sets bit 43, held.
// - Two address parity failures set bit 44.
// - Uncorrected ECC sets bit 45, syndrome protected.
// - Corrected ECC sets bit 46.
// - Syndrome captured only when bit 45 clear.
// - Variant uses a 23-bit timeout counter.
// - Variant prescaler counts crystal clock cycles.
// The counts are parameters so that a test can shorten the timeout chain;
// LONG_CNT_W must stay below the 24-bit width of the counter register.
module bes_logger #(
	parameter int SHORT_CNT_W = bes_pkg::TO_SHORT_W,
	parameter int LONG_CNT_W = bes_pkg::TO_LONG_W,
	parameter logic [7:0] PRESCALE_TOP = bes_pkg::PRESCALE_LAST
) (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic [bes_pkg::ADDR_W-1:0] addr_i,
	input wire logic [bes_pkg::DATA_W-1:0] wdata_i,
	input wire logic write_i,
	input wire logic read_i,
	output logic [bes_pkg::DATA_W-1:0] rdata_o,
	input wire logic bus_init_signal_n_i,
	input wire logic [2:0] response_status_lines_n_i,
	input wire logic response_parity_pin_n_i,
	input wire logic response_valid_n_i,
	input wire logic crystal_clock_i,
	input wire logic retire_i,
	input wire logic exception_i,
	input wire logic split_hard_error_i,
	input wire logic hard_error_i,
	input wire logic internal_failure_i,
	input wire logic address_parity_failure_i,
	input wire logic ecc_valid_i,
	input wire logic uncorrectable_ecc_flag_i,
	input wire logic [7:0] ecc_syndrome_i,
	output logic timeout_bus_init_o,
	output logic internal_failure_pin_o,
	output logic irq_o
);

	////////////////////////////////////////////////////////////////////////////////

	// Hardware set wins over a software clear in the same cycle.
	function automatic logic sticky(input logic cur, input logic set, input logic clr);
		sticky = set | (cur & ~clr);
	endfunction

	function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] ofs);
		reg_hit = (addr == ofs);
	endfunction

	bes_pkg::bes_state_t q;
	bes_pkg::bes_state_t d;

	bes_pkg::bes_pins_t pins_now;
	logic wr_status;
	logic wr_config;
	logic wr_irq_enable;
	logic wr_irq_clear;
	logic ext_bus_init_signal_ev;
	logic parity_ev;
	logic xtal_tick;
	logic bus_tick;
	logic [1:0] div_last;
	logic prescale_tick;
	logic prescale_carry;
	logic [23:0] to_next;
	logic to_carry;
	logic to_clear;
	logic address_parity_failure_hit;
	logic corrected_ecc_flag_ev;
	logic uncorrectable_ecc_flag_ev;
	logic [8:0] ev;
	logic [8:0] irq_clr;
	logic [63:0] clr_mask;
	logic [63:0] rd_mux;

	////////////////////////////////////////////////////////////////////////////////

	always_comb begin
		d = q;

		// Pins from the bus are active low; two flip-flops before any use.
		pins_now.bus_init = ~bus_init_signal_n_i;
		pins_now.rs = ~response_status_lines_n_i;
		pins_now.rsp = ~response_parity_pin_n_i;
		pins_now.rs_valid = ~response_valid_n_i;
		pins_now.xtal = crystal_clock_i;
		d.pin_s1 = pins_now;
		d.pin_s2 = q.pin_s1;
		d.bus_init_prev = q.pin_s2.bus_init;
		d.xtal_prev = q.pin_s2.xtal;

		wr_status = write_i && reg_hit(addr_i, bes_pkg::OFS_STATUS);
		wr_config = write_i && reg_hit(addr_i, bes_pkg::OFS_CONFIG);
		wr_irq_enable = write_i && reg_hit(addr_i, bes_pkg::OFS_IRQ_ENABLE);
		wr_irq_clear = write_i && reg_hit(addr_i, bes_pkg::OFS_IRQ_CLEAR);

		if (wr_config) begin
			d.cfg = wdata_i[3:0];
		end
		if (wr_irq_enable) begin
			d.irq_enable = wdata_i[bes_pkg::IRQ_W-1:0];
		end

		// Only a rising edge of an external bus-init counts; the block's own
		// timeout bus-init goes out on a separate pin and is not looped back.
		ext_bus_init_signal_ev = q.pin_s2.bus_init && !q.bus_init_prev;

		// Even parity over the three response lines and the parity pin.
		parity_ev = q.pin_s2.rs_valid && (^{q.pin_s2.rs, q.pin_s2.rsp});

		////////////////////////////////////////////////////////////////////////

		// Bus clock is a divided enable of the core clock.
		unique case (q.cfg[bes_pkg::CFG_RATIO_MSB:bes_pkg::CFG_RATIO_LSB])
			bes_pkg::RATIO_HALF: div_last = 2'h1;
			bes_pkg::RATIO_THIRD: div_last = 2'h2;
			default: div_last = 2'h3;
		endcase
		bus_tick = (q.div_cnt == div_last);
		d.div_cnt = bus_tick ? 2'h0 : q.div_cnt + 2'h1;

		// The crystal tick is a synchronised rising edge, so the crystal must
		// run below half the core clock to be counted faithfully.
		xtal_tick = q.pin_s2.xtal && !q.xtal_prev;
		prescale_tick = q.cfg[bes_pkg::CFG_XTAL_SRC] ? xtal_tick : bus_tick;

		prescale_carry = prescale_tick && (q.prescale == PRESCALE_TOP);
		if (prescale_tick) begin
			d.prescale = prescale_carry ? 8'h00 : q.prescale + 8'h01;
		end

		to_next = q.to_cnt + 24'h000001;
		if (q.cfg[bes_pkg::CFG_LONG_COUNTER]) begin
			to_carry = prescale_carry && to_next[LONG_CNT_W];
		end else begin
			to_carry = prescale_carry && to_next[SHORT_CNT_W];
		end

		// A carry clears the counter at once, so it never sits past its width.
		to_clear = retire_i || exception_i || q.to_bus_init_signal || to_carry;
		if (to_clear) begin
			d.to_cnt = 24'h000000;
		end else if (prescale_carry) begin
			d.to_cnt = to_next;
		end
		d.to_bus_init_signal = to_carry;

		////////////////////////////////////////////////////////////////////////

		// Address parity failures are counted until the second one.
		address_parity_failure_hit = 1'b0;
		if (address_parity_failure_i) begin
			if (q.address_parity_failure_cnt == 2'(bes_pkg::ADDRESS_PARITY_FAILURE_LIMIT - 1)) begin
				address_parity_failure_hit = 1'b1;
				d.address_parity_failure_cnt = 2'h0;
			end else begin
				d.address_parity_failure_cnt = q.address_parity_failure_cnt + 2'h1;
			end
		end

		corrected_ecc_flag_ev = ecc_valid_i && !uncorrectable_ecc_flag_i;
		uncorrectable_ecc_flag_ev = ecc_valid_i && uncorrectable_ecc_flag_i;

		// Software clears a bit by writing zero to it; ones leave it alone.
		clr_mask = wr_status ? ~wdata_i : 64'h0000000000000000;

		d.status[bes_pkg::BIT_EXT_BUS_INIT_SIGNAL] = sticky(q.status[bes_pkg::BIT_EXT_BUS_INIT_SIGNAL],
			ext_bus_init_signal_ev, clr_mask[bes_pkg::BIT_EXT_BUS_INIT_SIGNAL]);
		d.status[bes_pkg::BIT_RSP_PARITY] = sticky(q.status[bes_pkg::BIT_RSP_PARITY],
			parity_ev, clr_mask[bes_pkg::BIT_RSP_PARITY]);
		d.status[bes_pkg::BIT_SPLIT_HARD] = sticky(q.status[bes_pkg::BIT_SPLIT_HARD],
			split_hard_error_i, clr_mask[bes_pkg::BIT_SPLIT_HARD]);
		d.status[bes_pkg::BIT_TIMEOUT] = sticky(q.status[bes_pkg::BIT_TIMEOUT],
			to_carry, clr_mask[bes_pkg::BIT_TIMEOUT]);
		d.status[bes_pkg::BIT_HARD_ERR] = sticky(q.status[bes_pkg::BIT_HARD_ERR],
			hard_error_i, clr_mask[bes_pkg::BIT_HARD_ERR]);
		d.status[bes_pkg::BIT_INTERNAL] = sticky(q.status[bes_pkg::BIT_INTERNAL],
			internal_failure_i, clr_mask[bes_pkg::BIT_INTERNAL]);
		d.status[bes_pkg::BIT_ADDR_PARITY] = sticky(q.status[bes_pkg::BIT_ADDR_PARITY],
			address_parity_failure_hit, clr_mask[bes_pkg::BIT_ADDR_PARITY]);
		d.status[bes_pkg::BIT_UNCORRECTABLE_ECC_FLAG] = sticky(q.status[bes_pkg::BIT_UNCORRECTABLE_ECC_FLAG],
			uncorrectable_ecc_flag_ev, clr_mask[bes_pkg::BIT_UNCORRECTABLE_ECC_FLAG]);
		d.status[bes_pkg::BIT_CORRECTED_ECC_FLAG] = sticky(q.status[bes_pkg::BIT_CORRECTED_ECC_FLAG],
			corrected_ecc_flag_ev, clr_mask[bes_pkg::BIT_CORRECTED_ECC_FLAG]);

		// The syndrome is guarded by the bit 45 held before this cycle, so a
		// clear and a new error in one cycle do not capture the new syndrome.
		if (ecc_valid_i && !q.status[bes_pkg::BIT_UNCORRECTABLE_ECC_FLAG]) begin
			d.status[bes_pkg::SYN_MSB:bes_pkg::SYN_LSB] = ecc_syndrome_i;
		end else if (wr_status && wdata_i[bes_pkg::SYN_MSB:bes_pkg::SYN_LSB] == 8'h00) begin
			d.status[bes_pkg::SYN_MSB:bes_pkg::SYN_LSB] = 8'h00;
		end

		////////////////////////////////////////////////////////////////////////

		ev = '0;
		ev[bes_pkg::IRQ_EXT_BUS_INIT_SIGNAL] = ext_bus_init_signal_ev;
		ev[bes_pkg::IRQ_RSP_PARITY] = parity_ev;
		ev[bes_pkg::IRQ_SPLIT_HARD] = split_hard_error_i;
		ev[bes_pkg::IRQ_TIMEOUT] = to_carry;
		ev[bes_pkg::IRQ_HARD_ERR] = hard_error_i;
		ev[bes_pkg::IRQ_INTERNAL] = internal_failure_i;
		ev[bes_pkg::IRQ_ADDR_PARITY] = address_parity_failure_hit;
		ev[bes_pkg::IRQ_UNCORRECTABLE_ECC_FLAG] = uncorrectable_ecc_flag_ev;
		ev[bes_pkg::IRQ_CORRECTED_ECC_FLAG] = corrected_ecc_flag_ev;
		irq_clr = wr_irq_clear ? wdata_i[bes_pkg::IRQ_W-1:0] : 9'h000;
		for (int i = 0; i < bes_pkg::IRQ_W; i++) begin
			d.irq_status[i] = sticky(q.irq_status[i], ev[i], irq_clr[i]);
		end
		d.irq = |(d.irq_status & d.irq_enable);

		////////////////////////////////////////////////////////////////////////

		rd_mux = 64'h0000000000000000;
		unique case (addr_i)
			bes_pkg::OFS_STATUS: rd_mux = q.status;
			bes_pkg::OFS_CONFIG: rd_mux = {60'h000000000000000, q.cfg};
			bes_pkg::OFS_IRQ_STATUS: rd_mux = {55'h0, q.irq_status};
			bes_pkg::OFS_IRQ_ENABLE: rd_mux = {55'h0, q.irq_enable};
			bes_pkg::OFS_TIMEOUT_COUNT: rd_mux = {40'h0000000000, q.to_cnt};
			default: rd_mux = 64'h0000000000000000;
		endcase
		d.rdata = read_i ? rd_mux : 64'h0000000000000000;
	end

	always_ff @(posedge clock_i) begin
		if (!rstn_i) begin
			q <= bes_pkg::STATE_RESET;
		end else begin
			q <= d;
		end
	end

	assign rdata_o = q.rdata;
	assign timeout_bus_init_o = q.to_bus_init_signal;
	assign internal_failure_pin_o = q.status[bes_pkg::BIT_INTERNAL];
	assign irq_o = q.irq;

endmodule // bes_logger

// >>> sim/bes_bus_agent.sv
// Behavioural model of the external bus agent that drives the response and bus-init pins.
`timescale 1ns/1ps
module bes_bus_agent (
	input wire logic clock_i,
	input wire logic bus_init_signal_req_i,
	input wire logic resp_req_i,
	input wire logic [2:0] resp_code_i,
	input wire logic bad_parity_i,
	output logic bus_init_signal_n_o = 1'b1,
	output logic [2:0] response_status_lines_n_o = 3'h7,
	output logic response_parity_pin_n_o = 1'b1,
	output logic response_valid_n_o = 1'b1
);
	// Released lines sit at the pull-up level, so idle pins read high.
	always_ff @(posedge clock_i) begin
		bus_init_signal_n_o <= !bus_init_signal_req_i;
		response_valid_n_o <= !resp_req_i;
		response_status_lines_n_o <= resp_req_i ? ~resp_code_i : 3'h7;
		response_parity_pin_n_o <= resp_req_i ? ~(^resp_code_i ^ bad_parity_i) : 1'b1;
	end
endmodule // bes_bus_agent

// >>> sim/bes_checker.sv
// Port-level assertions for the bus error status logger.
`timescale 1ns/1ps
module bes_checker (
	input wire logic clock_i,
	input wire logic rstn_i,
	input wire logic [7:0] addr_i,
	input wire logic [63:0] wdata_i,
	input wire logic write_i,
	input wire logic read_i,
	input wire logic [63:0] rdata_o,
	input wire logic internal_failure_i,
	input wire logic retire_i,
	input wire logic timeout_bus_init_o,
	input wire logic internal_failure_pin_o,
	input wire logic irq_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rstn_i);
	a_rdata_idle: assert property (!read_i |=> rdata_o == '0)
		else $error("read data not zero");
	a_unmapped_zero: assert property (read_i && addr_i == 8'h30 |=> rdata_o == '0)
		else $error("unmapped read not zero");
	a_status_reserved: assert property (read_i && addr_i == 8'h00 |=>
		rdata_o[34:0] == '0 && rdata_o[41:39] == '0 && rdata_o[63:55] == '0)
		else $error("status reserved bits set");
	a_ifail_set: assert property (internal_failure_i |-> ##[1:2] internal_failure_pin_o)
		else $error("internal failure pin late");
	a_ifail_hold: assert property (internal_failure_pin_o && !write_i |=> internal_failure_pin_o)
		else $error("internal failure pin dropped");
	a_ifail_clear: assert property (write_i && addr_i == 8'h00 && !wdata_i[43] && !internal_failure_i
		##1 !internal_failure_i |-> ##1 !internal_failure_pin_o)
		else $error("internal failure pin not cleared");
	a_timeout_single: assert property (timeout_bus_init_o |=> !timeout_bus_init_o [*8])
		else $error("timeout pulse repeated");
	a_retire_quiet: assert property (retire_i |-> ##2 !timeout_bus_init_o [*8])
		else $error("timeout right after retire");
	a_cfg_width: assert property (read_i && addr_i == 8'h08 |=> rdata_o[63:4] == '0)
		else $error("config upper bits set");
	a_irq_off: assert property (write_i && addr_i == 8'h18 && wdata_i[8:0] == '0 ##1 !write_i
		|-> ##1 !irq_o)
		else $error("irq high with nothing enabled");
endmodule // bes_checker
bind bes_logger bes_checker u_bes_checker (.clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr_i),
	.wdata_i(wdata_i), .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o),
	.internal_failure_i(internal_failure_i), .retire_i(retire_i),
	.timeout_bus_init_o(timeout_bus_init_o), .internal_failure_pin_o(internal_failure_pin_o),
	.irq_o(irq_o));

// >>> sim/testbench.sv
// Self-checking bench for the bus error status logger.
`timescale 1ns/1ps
module testbench;
	logic clock_i = 1'b0, rstn_i = 1'b0, write_i = 1'b0, read_i = 1'b0, rd_seen = 1'b0;
	// Retire stays high until the timeout tests, so no expiry disturbs the early checks.
	logic retire_i = 1'b1, exception_i = 1'b0, xtal = 1'b0, bi = 1'b0, rq = 1'b0, bad = 1'b0;
	logic [2:0] code = 3'h0;
	logic [5:0] evt = 6'h00;
	logic [7:0] addr_i = 8'h00, syn = 8'h00;
	logic [7:0] ofs[7] = '{8'h00, 8'h08, 8'h10, 8'h18, 8'h20, 8'h28, 8'h30};
	logic [63:0] wdata_i = '0, rdata_o, st = '0;
	logic [63:0] exp_q[$];
	logic bin_n, rsp_n, val_n, tbi, ifp, irq_o;
	logic [2:0] rs_n;
	int err_count = 0, checks_done = 0, cyc = 0, to_seen = 0;
	initial forever #25 clock_i = ~clock_i;
	bes_bus_agent u_bes_bus_agent (.clock_i(clock_i), .bus_init_signal_req_i(bi), .resp_req_i(rq),
		.resp_code_i(code), .bad_parity_i(bad), .bus_init_signal_n_o(bin_n),
		.response_status_lines_n_o(rs_n), .response_parity_pin_n_o(rsp_n),
		.response_valid_n_o(val_n));
	// Short timeout chain: a carry every 4 ticks, expiry after 16 or 64 carries.
	bes_logger #(.SHORT_CNT_W(4), .LONG_CNT_W(6), .PRESCALE_TOP(8'h03)) u_bes_logger (
		.clock_i(clock_i), .rstn_i(rstn_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .write_i(write_i), .read_i(read_i), .rdata_o(rdata_o),
		.bus_init_signal_n_i(bin_n), .response_status_lines_n_i(rs_n),
		.response_parity_pin_n_i(rsp_n), .response_valid_n_i(val_n), .crystal_clock_i(xtal),
		.retire_i(retire_i), .exception_i(exception_i), .split_hard_error_i(evt[0]),
		.hard_error_i(evt[1]), .internal_failure_i(evt[2]), .address_parity_failure_i(evt[3]),
		.ecc_valid_i(evt[4]), .uncorrectable_ecc_flag_i(evt[5]), .ecc_syndrome_i(syn),
		.timeout_bus_init_o(tbi), .internal_failure_pin_o(ifp), .irq_o(irq_o));
	task automatic give_verdict();
		$display("checks %0d, mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic check(input logic [63:0] seen, input logic [63:0] want);
		checks_done++;
		if (seen !== want) begin
			err_count++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, want);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
	endtask
	task automatic wr(input logic [7:0] a, input logic [63:0] d);
		addr_i <= a;
		wdata_i <= d;
		write_i <= 1'b1;
		tick(1);
		write_i <= 1'b0;
		tick(1);
	endtask
	task automatic rd(input logic [7:0] a, input logic [63:0] e);
		exp_q.push_back(e);
		addr_i <= a;
		read_i <= 1'b1;
		tick(1);
		read_i <= 1'b0;
		tick(1);
	endtask
	task automatic fire(input logic [5:0] e, input logic [7:0] s = 8'h00);
		evt <= e;
		syn <= s;
		tick(1);
		evt <= 6'h00;
		tick(1);
	endtask
	task automatic xticks(input int n);
		repeat (n) begin
			xtal <= 1'b1;
			tick(2);
			xtal <= 1'b0;
			tick(2);
		end
		tick(6);
	endtask
	// Read data is only valid in the cycle after the strobe, so compare exactly there.
	always @(posedge clock_i) begin
		cyc++;
		if (rd_seen)
			check(rdata_o, exp_q.pop_front());
		rd_seen <= read_i;
		if (tbi)
			to_seen++;
		if (cyc == 8000) begin
			err_count++;
			give_verdict();
		end
	end
	initial begin
		logic [7:0] s;
		void'($urandom(48));
		tick(12);
		rstn_i <= 1'b1;
		tick(1);
		foreach (ofs[i]) rd(ofs[i], '0);
		$display("test reset done");
		wr(8'h18, 64'h1ff);
		fire(6'h02);
		fire(6'h04);
		check(64'(ifp), 64'h1);
		fire(6'h01);
		fire(6'h08);
		st = (64'h1 << 37) | (64'h3 << 42);
		rd(8'h00, st);
		fire(6'h08);
		s = $urandom;
		fire(6'h10, s);
		s = $urandom;
		fire(6'h30, s);
		fire(6'h10, ~s);
		st[46:44] = 3'h7;
		st[54:47] = s;
		rd(8'h00, st);
		bi <= 1'b1;
		tick(3);
		bi <= 1'b0;
		for (int k = 0; k < 8; k++) begin
			code <= 3'(k);
			rq <= 1'b1;
			tick(1);
			rq <= 1'b0;
			tick(1);
		end
		tick(6);
		st[35] = 1'b1;
		rd(8'h00, st);
		bad <= 1'b1;
		rq <= 1'b1;
		tick(1);
		rq <= 1'b0;
		tick(6);
		st[36] = 1'b1;
		rd(8'h00, st);
		rd(8'h10, 64'h1f7);
		check(64'(irq_o), 64'h1);
		$display("test events done");
		wr(8'h00, 64'h1 << 42);
		check(64'(ifp), 64'h0);
		st = 64'h1 << 42;
		rd(8'h00, st);
		s = $urandom;
		fire(6'h30, s);
		st[45] = 1'b1;
		st[54:47] = s;
		rd(8'h00, st);
		wr(8'h18, 64'h0);
		wr(8'h20, 64'h1ff);
		fire(6'h02);
		rd(8'h10, 64'h010);
		check(64'(irq_o), 64'h0);
		wr(8'h18, 64'h010);
		tick(2);
		check(64'(irq_o), 64'h1);
		wr(8'h20, 64'h010);
		tick(2);
		check(64'(irq_o), 64'h0);
		$display("test clear done");
		s = $urandom;
		wr(8'h08, 64'(s[3:0]));
		rd(8'h08, 64'(s[3:0]));
		wr(8'h08, 64'h8);
		retire_i <= 1'b1;
		tick(1);
		retire_i <= 1'b0;
		xticks(12);
		rd(8'h28, 64'h3);
		fire(6'h00);
		retire_i <= 1'b1;
		tick(1);
		retire_i <= 1'b0;
		rd(8'h28, 64'h0);
		xticks(4);
		rd(8'h28, 64'h1);
		exception_i <= 1'b1;
		tick(1);
		exception_i <= 1'b0;
		rd(8'h28, 64'h0);
		$display("test timeout done");
		wr(8'h08, 64'h0);
		tick(140);
		check(64'(to_seen), 64'h1);
		st[38] = 1'b1;
		rd(8'h00, st);
		rd(8'h10, 64'h008);
		tick(126);
		check(64'(to_seen), 64'h2);
		rd(8'h00, st);
		wr(8'h08, 64'h4);
		retire_i <= 1'b1;
		tick(1);
		retire_i <= 1'b0;
		tick(300);
		check(64'(to_seen), 64'h2);
		tick(260);
		check(64'(to_seen), 64'h3);
		$display("test expiry done");
		tick(2);
		give_verdict();
	end
endmodule // testbench
